// >>> rtl/bidl_pkg.sv
/*
 board id and led control package: field positions, reset values, timing.
 assumes nothing beyond a single 20 MHz clock.
*/
package bidl_pkg;
	localparam int unsigned CLK_HZ           = 20_000_000;
	localparam int unsigned ID_W             = 4;
	localparam int unsigned ID_LSB           = 0;
	localparam int unsigned TERM_OFF_BIT     = 30;
	localparam int unsigned BRD_RED_BIT      = 25;
	localparam int unsigned BRD_GRN_BIT      = 24;
	localparam int unsigned CH_RED_HI        = 23;
	localparam int unsigned CH_RED_LO        = 22;
	localparam int unsigned CH_GRN_HI        = 21;
	localparam int unsigned CH_GRN_LO        = 20;
	localparam int unsigned NUM_CH           = 4;
	localparam logic [1:0]  LED_FORCE_OFF    = 2'h2;
	localparam logic [1:0]  LED_FORCE_ON     = 2'h3;
	localparam logic [3:0]  FW_REV_RST       = 4'h0;
	localparam int unsigned FLASH_HALF_MS    = 250;
	localparam int unsigned FLASH_HALF_CYC   = CLK_HZ / 1000 * FLASH_HALF_MS;
	localparam int unsigned FLASH_TOGGLES    = 6;
	typedef enum logic [1:0] {BIDL_ST_FLASH, BIDL_ST_IDLE} bidl_state_t;
endpackage

// >>> rtl/bidl_sync.sv
/*
 two flip-flop synchroniser for a bus of levels.
 assumes inputs are asynchronous to core_clk_in.
*/
`timescale 1ns/1ps
module bidl_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         core_clk_in,
	input  wire logic         sys_rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	if (W < 1) begin : g_bad_w
		$error("bidl_sync: W must be at least 1");
	end

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} bidl_sync_regs_t;

	bidl_sync_regs_t s_r, s_nxt;

	// only the second stage is read outside
	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = d_in;
		s_nxt.q    = s_r.meta;
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q_out = s_r.q;
endmodule

// >>> rtl/bidl_top.sv
/*
 board identity readback, termination disable, board/channel leds, status flash.
 assumes control words come from same-clock register logic; jumpers are pins.
*/
// Notes on behaviour
// - fitted jumper reads one, open reads zero
// - jumpers map in order to bits 0..3
// - bit 30 disables receiver termination
// - board bits 25 red, 24 green
// - channel bits 23:22: 10 off, 11 on
// - channel bits 21:20 drive green led
// - channels 4,3,2,1 own pairs 1..4
// - all channel bits 23:20 zero: greens show revision
// - status leds flash after reset, then off
`timescale 1ns/1ps
module bidl_top
	import bidl_pkg::*;
#(
	parameter int unsigned HALF_CYC = FLASH_HALF_CYC
) (
	input  wire logic              core_clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic [ID_W-1:0]   board_id_jumper_in,
	input  wire logic [31:0]       pin_source_in,
	input  wire logic [31:0]       board_control_in,
	input  wire logic [31:0]       ch1_control_in,
	input  wire logic [31:0]       ch2_control_in,
	input  wire logic [31:0]       ch3_control_in,
	input  wire logic [31:0]       ch4_control_in,
	input  wire logic [3:0]        fw_revision_in,
	output logic      [31:0]       board_status_out,
	output logic                   term_disable_out,
	output logic [1:0]             board_led_pair_out,
	output logic [1:0]             channel4_led_pair_out,
	output logic [1:0]             channel3_led_pair_out,
	output logic [1:0]             channel2_led_pair_out,
	output logic [1:0]             channel1_led_pair_out,
	output logic [1:0]             firmware_status_leds_out
);
	// flash counter is 24 bits wide, toggle counter 4 bits
	if (HALF_CYC < 1 || HALF_CYC > 32'hffffff || FLASH_TOGGLES > 16) begin : g_bad_half
		$error("bidl_top: HALF_CYC out of range");
	end

	typedef struct packed {
		bidl_state_t st;
		logic [23:0] cnt;
		logic [3:0]  tog;
		logic        flash;
		logic [31:0] status;
		logic        term;
		logic [1:0]  brd;
		logic [NUM_CH-1:0][1:0] led;
		logic [1:0]  fw;
	} bidl_regs_t;

	bidl_regs_t s_r, s_nxt;
	logic [ID_W-1:0] jumper_sync;
	logic [31:0]     ctl [NUM_CH];
	logic            all_zero;
	logic [1:0]      rf, gf;

	bidl_sync #(.W(ID_W)) u_sync (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.d_in        (board_id_jumper_in),
		.q_out       (jumper_sync)
	);

	// pair order: index 0 = first pair = channel 4
	assign ctl[0] = ch4_control_in;
	assign ctl[1] = ch3_control_in;
	assign ctl[2] = ch2_control_in;
	assign ctl[3] = ch1_control_in;

	always_comb begin
		s_nxt    = s_r;
		all_zero = 1'b1;
		rf       = 2'h0;
		gf       = 2'h0;
		s_nxt.status = '0;
		s_nxt.status[ID_LSB +: ID_W] = jumper_sync;
		s_nxt.term = pin_source_in[TERM_OFF_BIT];
		s_nxt.brd  = {board_control_in[BRD_RED_BIT], board_control_in[BRD_GRN_BIT]};
		for (int i = 0; i < NUM_CH; i++) begin
			if (ctl[i][CH_RED_HI:CH_GRN_LO] != 4'h0)
				all_zero = 1'b0;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			rf = ctl[i][CH_RED_HI:CH_RED_LO];
			gf = ctl[i][CH_GRN_HI:CH_GRN_LO];
			s_nxt.led[i][1] = 1'b0;
			if (rf == LED_FORCE_ON)
				s_nxt.led[i][1] = 1'b1;
			s_nxt.led[i][0] = 1'b0;
			if (all_zero)
				s_nxt.led[i][0] = fw_revision_in[i];
			else if (gf == LED_FORCE_ON)
				s_nxt.led[i][0] = 1'b1;
		end
		case (s_r.st)
			BIDL_ST_FLASH: begin
				if (s_r.cnt == 24'(HALF_CYC - 1)) begin
					s_nxt.cnt   = '0;
					s_nxt.flash = ~s_r.flash;
					s_nxt.tog   = s_r.tog + 4'h1;
					if (s_r.tog == 4'(FLASH_TOGGLES - 1)) begin
						s_nxt.st    = BIDL_ST_IDLE;
						s_nxt.flash = 1'b0;
					end
				end else begin
					s_nxt.cnt = s_r.cnt + 24'h1;
				end
			end
			BIDL_ST_IDLE: s_nxt.flash = 1'b0;
			default: s_nxt.st = BIDL_ST_IDLE;
		endcase
		s_nxt.fw = {2{s_nxt.flash}};
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_r.st     <= BIDL_ST_FLASH;
			s_r.cnt    <= '0;
			s_r.tog    <= '0;
			s_r.flash  <= 1'b1;
			s_r.status <= '0;
			s_r.term   <= 1'b0;
			s_r.brd    <= '0;
			s_r.led    <= '0;
			s_r.fw     <= 2'h3;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign board_status_out         = s_r.status;
	assign term_disable_out         = s_r.term;
	assign board_led_pair_out       = s_r.brd;
	assign channel4_led_pair_out    = s_r.led[0];
	assign channel3_led_pair_out    = s_r.led[1];
	assign channel2_led_pair_out    = s_r.led[2];
	assign channel1_led_pair_out    = s_r.led[3];
	assign firmware_status_leds_out = s_r.fw;
endmodule

// >>> sim/bidl_top_assertions.sv
/* port checker for bidl_top.
 assumes one clock, async active-high reset. */
`timescale 1ns/1ps
module bidl_top_chk #(
	parameter int unsigned HALF_CYC = 4
) (
	input wire logic        core_clk_in,
	input wire logic        sys_rst_in,
	input wire logic [3:0]  board_id_jumper_in,
	input wire logic [31:0] pin_source_in,
	input wire logic [31:0] board_control_in,
	input wire logic [31:0] ch1_control_in,
	input wire logic [31:0] ch2_control_in,
	input wire logic [31:0] ch3_control_in,
	input wire logic [31:0] ch4_control_in,
	input wire logic [3:0]  fw_revision_in,
	input wire logic [31:0] board_status_out,
	input wire logic        term_disable_out,
	input wire logic [1:0]  board_led_pair_out,
	input wire logic [1:0]  channel4_led_pair_out,
	input wire logic [1:0]  channel1_led_pair_out,
	input wire logic [1:0]  firmware_status_leds_out
);
	localparam int LIM = 15 * HALF_CYC;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_run1; !$past(sys_rst_in); endsequence
	sequence s_run3; !sys_rst_in [*3]; endsequence
	a_term_off: assert property (s_run1 |-> term_disable_out == $past(pin_source_in[30]))
		else $error("term bad");
	a_brd_leds: assert property (s_run1 |-> board_led_pair_out == $past(board_control_in[25:24]))
		else $error("board leds bad");
	a_red_ch4: assert property (s_run1 |-> channel4_led_pair_out[1] ==
		($past(ch4_control_in[23:22]) == 2'h3)) else $error("ch4 red bad");
	a_red_ch1_off: assert property (s_run1 ##0 $past(ch1_control_in[23:22]) == 2'h2
		|-> !channel1_led_pair_out[1]) else $error("ch1 red bad");
	a_grn_ch4_on: assert property (s_run1 ##0 $past(ch4_control_in[21:20]) == 2'h3
		|-> channel4_led_pair_out[0]) else $error("ch4 green bad");
	a_grn_ch1_off: assert property (s_run1 ##0 $past(ch1_control_in[21:20]) == 2'h2
		|-> !channel1_led_pair_out[0]) else $error("ch1 green bad");
	a_rev_show: assert property (s_run1 ##0 $past({ch1_control_in[23:20],
		ch2_control_in[23:20], ch3_control_in[23:20], ch4_control_in[23:20]}) == 16'h0
		|-> {channel1_led_pair_out[0], channel4_led_pair_out[0]} ==
		{$past(fw_revision_in[3]), $past(fw_revision_in[0])}) else $error("rev bad");
	a_id_follow: assert property (s_run3 |=> board_status_out ==
		{28'h0, $past(board_id_jumper_in, 3)}) else $error("id bad");
	a_fw_pair: assert property (firmware_status_leds_out[0] == firmware_status_leds_out[1])
		else $error("fw pair bad");
	a_fw_settle: assert property ($fell(sys_rst_in) |-> ##[1:LIM] firmware_status_leds_out == 2'h0)
		else $error("fw not off");
endmodule
bind bidl_top bidl_top_chk #(.HALF_CYC(HALF_CYC)) u_chk (.*);

// >>> sim/bidl_top_test.sv
/* bench for bidl_top, ports driven directly.
 assumes HALF_CYC of 4. */
`timescale 1ns/1ps
module bidl_top_test;
	logic        clk = 0, rst = 1;
	logic [3:0]  jmp = 0, rev = 0;
	logic [31:0] ps = 0, bc = 0, c1 = 0, c2 = 0, c3 = 0, c4 = 0, st;
	logic        term;
	logic [1:0]  bl, l1, l2, l3, l4, fw;
	int          n_errors = 0, num_checks = 0;
	always #25 clk = ~clk;
	bidl_top #(.HALF_CYC(4)) dut (.core_clk_in(clk), .sys_rst_in(rst), .board_id_jumper_in(jmp),
		.pin_source_in(ps), .board_control_in(bc), .ch1_control_in(c1), .ch2_control_in(c2),
		.ch3_control_in(c3), .ch4_control_in(c4), .fw_revision_in(rev), .board_status_out(st),
		.term_disable_out(term), .board_led_pair_out(bl), .channel4_led_pair_out(l4),
		.channel3_led_pair_out(l3), .channel2_led_pair_out(l2), .channel1_led_pair_out(l1),
		.firmware_status_leds_out(fw));
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic check(string what, logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	function automatic logic on(logic [1:0] f);
		return f == 2'h3;
	endfunction
	task automatic flash();
		int lit;
		lit = 0;
		check("fw rst", fw, 2'h3);
		rst = 0;
		for (int i = 0; i < 60; i++) begin
			step(1);
			lit += fw[0];
		end
		check("fw lit", lit, 3 * 4 - 1);
		check("fw off", fw, 2'h0);
	endtask
	initial begin
		step(4);
		flash();
		rev = 4'ha;
		step(2);
		check("rev", {l1[0], l2[0], l3[0], l4[0]}, 4'ha);
		for (int v = 0; v < 4; v++) begin
			c1[23:20] = {2'(v + 1), 2'(v + 2)};
			c2[23:20] = {2'(v + 2), 2'(v + 3)};
			c3[23:20] = {2'(v + 3), 2'(v)};
			c4[23:20] = {2'(v), 2'(v + 1)};
			bc[25:24] = 2'(v);
			ps[30] = v[0];
			jmp = 4'(v * 5);
			step(4);
			check("ch1", l1, {on(c1[23:22]), on(c1[21:20])});
			check("ch2", l2, {on(c2[23:22]), on(c2[21:20])});
			check("ch3", l3, {on(c3[23:22]), on(c3[21:20])});
			check("ch4", l4, {on(c4[23:22]), on(c4[21:20])});
			check("board", bl, bc[25:24]);
			check("term", term, ps[30]);
			check("status", st, {28'h0, jmp});
		end
		rst = 1;
		step(4);
		flash();
		conclude();
	end
endmodule
